// ### common/mcirq_pkg.sv
// package for the miscellaneous clock and interrupt sense register
// assumes a classic wishbone slave with 32-bit data and one clock domain
//
// Notes on behaviour
// R1 - reset clears whole register to zero
// R2 - bits 7:6 set group b sensitivity
// R3 - bits 4:3 set group a sensitivity
// R4 - sense fields written only while interrupts masked
// R5 - unmasked write keeps sense fields, updates rest
// R6 - sense codes: low/fall, rise, fall, both
// R7 - bit 5 drives cpu clock onto pin
// R8 - prescale codes 00/4, 10/8, 01/16, 11/32
// R9 - bit 0 low gives half oscillator clock
package mcirq_pkg;
   // ***************************************
   // register map
   // ***************************************
   localparam logic [5:0] MCIRQ_MISC_CONTROL_ONE_IDX = 6'h00; // word index of the register
   localparam logic [7:0] MCIRQ_MISC_CONTROL_ONE_RST = 8'h00; // value after reset
   localparam int MCIRQ_SENSE_B_POS = 6; // group b sense field low bit
   localparam int MCIRQ_CLK_OUT_POS = 5; // clock output enable bit
   localparam int MCIRQ_SENSE_A_POS = 3; // group a sense field low bit
   localparam int MCIRQ_PRESCALE_POS = 1; // prescale field low bit
   localparam int MCIRQ_SLOW_POS = 0; // slow mode select bit
   localparam logic [7:0] MCIRQ_SENSE_MASK = 8'hD8; // bits held while interrupts enabled
   // ***************************************
   // line counts and codes
   // ***************************************
   localparam int MCIRQ_LINES = 8; // lines in each external interrupt group
   localparam int MCIRQ_DIV_BITS = 5; // divider counter width, up to divide by 32
   typedef enum logic [1:0]
   {
      MCIRQ_SENSE_FALL_LOW = 2'h0,
      MCIRQ_SENSE_RISE = 2'h1,
      MCIRQ_SENSE_FALL = 2'h2,
      MCIRQ_SENSE_BOTH = 2'h3
   } mcirq_sense_t;
   typedef enum logic [1:0]
   {
      MCIRQ_PRE_DIV4 = 2'h0,
      MCIRQ_PRE_DIV16 = 2'h1,
      MCIRQ_PRE_DIV8 = 2'h2,
      MCIRQ_PRE_DIV32 = 2'h3
   } mcirq_prescale_t;
   localparam logic [2:0] MCIRQ_TAP_DIV2 = 3'h0; // divider tap for half oscillator
   localparam logic [2:0] MCIRQ_TAP_DIV4 = 3'h1; // divider tap for divide by 4
   localparam logic [2:0] MCIRQ_TAP_DIV8 = 3'h2; // divider tap for divide by 8
   localparam logic [2:0] MCIRQ_TAP_DIV16 = 3'h3; // divider tap for divide by 16
   localparam logic [2:0] MCIRQ_TAP_DIV32 = 3'h4; // divider tap for divide by 32
endpackage

// ### src/mcirq_sense_det.sv
// edge and level detector for one group of external interrupt lines
// assumes pins are asynchronous and the mode comes from the same clock
`timescale 1ns/10ps
module mcirq_sense_det
   import mcirq_pkg::*;
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [1:0] sense_in,
   input wire logic [MCIRQ_LINES-1:0] pin_in,
   output logic [MCIRQ_LINES-1:0] event_out
);
   // ***************************************
   // synchroniser and history
   // ***************************************
   logic [MCIRQ_LINES-1:0] meta_r; // first stage, read only by sync_r
   logic [MCIRQ_LINES-1:0] sync_r; // second stage
   logic [MCIRQ_LINES-1:0] prev_r; // last sampled level
   logic [MCIRQ_LINES-1:0] event_r; // registered detect
   logic [MCIRQ_LINES-1:0] event_nxt; // detect from mode
   mcirq_sense_t mode; // decoded mode

   // decode mode into line events
   always_comb
   begin
      mode = mcirq_sense_t'(sense_in);
      case (mode)
         MCIRQ_SENSE_FALL_LOW: event_nxt = ~sync_r; // R6
         MCIRQ_SENSE_RISE: event_nxt = sync_r & ~prev_r; // R6
         MCIRQ_SENSE_FALL: event_nxt = ~sync_r & prev_r; // R6
         MCIRQ_SENSE_BOTH: event_nxt = sync_r ^ prev_r; // R6
         default: event_nxt = '0;
      endcase
   end

   // register stages; lines idle high
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         meta_r <= '1;
         sync_r <= '1;
         prev_r <= '1;
         event_r <= '0;
      end
      else
      begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
         event_r <= event_nxt;
      end
   end

   assign event_out = event_r;
endmodule

// ### src/mcirq_misc_reg.sv
// miscellaneous control register: interrupt sense, clock out, cpu prescaler
// assumes clock_in is the oscillator and int_mask_in is on the same clock
`timescale 1ns/10ps
module mcirq_misc_reg
   import mcirq_pkg::*;
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   // wishbone classic slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // cpu interrupt mask bit from condition code register
   input wire logic int_mask_in,
   // external interrupt pins
   input wire logic [MCIRQ_LINES-1:0] ext_int_group_a_in,
   input wire logic [MCIRQ_LINES-1:0] ext_int_group_b_in,
   output logic [MCIRQ_LINES-1:0] ext_int_group_a_event_out,
   output logic [MCIRQ_LINES-1:0] ext_int_group_b_event_out,
   // cpu clock
   output logic cpu_clock_out,
   // port c pin two, general purpose or clock out
   input wire logic gpio_pc2_out_in,
   input wire logic gpio_pc2_oe_in,
   output logic port_c_pin_two_out,
   output logic port_c_pin_two_oe_out
);
   // ***************************************
   // register and bus state
   // ***************************************
   logic [7:0] misc_control_one_r; // the register
   logic [7:0] misc_control_one_nxt;
   logic ack_r; // bus acknowledge
   logic ack_nxt;
   logic [31:0] rdata_r; // read data
   logic [31:0] rdata_nxt;
   logic hit; // address matches register
   logic wr_take; // write takes effect this edge
   logic [7:0] keep_mask; // bits not written this time

   // ***************************************
   // clock divider state
   // ***************************************
   logic [MCIRQ_DIV_BITS-1:0] div_cnt_r; // free running divider
   logic [MCIRQ_DIV_BITS-1:0] div_cnt_nxt;
   logic cpu_clk_r; // cpu clock level
   logic cpu_clk_nxt;
   logic [2:0] tap; // selected divider bit
   logic pin_r; // pin output level
   logic pin_nxt;
   logic pin_oe_r; // pin output enable
   logic pin_oe_nxt;

   // bus decode and register update
   always_comb
   begin
      hit = (wb_adr_in[7:2] == MCIRQ_MISC_CONTROL_ONE_IDX);
      ack_nxt = wb_cyc_in & wb_stb_in & ~ack_r;
      // write lands on the edge where the master sees ack
      wr_take = wb_cyc_in & wb_stb_in & wb_we_in & ack_r & hit & wb_sel_in[0];
      // sense fields frozen while interrupts are enabled
      keep_mask = int_mask_in ? 8'h00 : MCIRQ_SENSE_MASK; // R4 R5
      misc_control_one_nxt = misc_control_one_r;
      if (wr_take)
      begin
         misc_control_one_nxt = (wb_dat_in[7:0] & ~keep_mask)
            | (misc_control_one_r & keep_mask); // R5
      end
      rdata_nxt = rdata_r;
      if (wb_cyc_in & wb_stb_in & ~ack_r)
      begin
         // unmapped reads return zero
         rdata_nxt = hit ? {24'h000000, misc_control_one_r} : 32'h00000000;
      end
   end

   // register bus flops
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         misc_control_one_r <= MCIRQ_MISC_CONTROL_ONE_RST; // R1
         ack_r <= 1'b0;
         rdata_r <= 32'h00000000;
      end
      else
      begin
         misc_control_one_r <= misc_control_one_nxt;
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign wb_ack_out = ack_r;
   assign wb_dat_out = rdata_r;

   // ***************************************
   // cpu clock generation
   // ***************************************
   // choose tap from slow mode and prescaler
   always_comb
   begin
      if (!misc_control_one_r[MCIRQ_SLOW_POS])
      begin
         tap = MCIRQ_TAP_DIV2; // R9
      end
      else
      begin
         case (mcirq_prescale_t'(misc_control_one_r[MCIRQ_PRESCALE_POS +: 2])) // R8
            MCIRQ_PRE_DIV4: tap = MCIRQ_TAP_DIV4;
            MCIRQ_PRE_DIV8: tap = MCIRQ_TAP_DIV8;
            MCIRQ_PRE_DIV16: tap = MCIRQ_TAP_DIV16;
            MCIRQ_PRE_DIV32: tap = MCIRQ_TAP_DIV32;
            default: tap = MCIRQ_TAP_DIV2;
         endcase
      end
      div_cnt_nxt = div_cnt_r + 5'h01;
      cpu_clk_nxt = div_cnt_nxt[tap];
      // clock out replaces general purpose use of the pin
      if (misc_control_one_r[MCIRQ_CLK_OUT_POS])
      begin
         pin_nxt = cpu_clk_nxt; // R7
         pin_oe_nxt = 1'b1;
      end
      else
      begin
         pin_nxt = gpio_pc2_out_in; // R7
         pin_oe_nxt = gpio_pc2_oe_in;
      end
   end

   // divider and pin flops
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         div_cnt_r <= '0;
         cpu_clk_r <= 1'b0;
         pin_r <= 1'b0;
         pin_oe_r <= 1'b0;
      end
      else
      begin
         div_cnt_r <= div_cnt_nxt;
         cpu_clk_r <= cpu_clk_nxt;
         pin_r <= pin_nxt;
         pin_oe_r <= pin_oe_nxt;
      end
   end

   assign cpu_clock_out = cpu_clk_r;
   assign port_c_pin_two_out = pin_r;
   assign port_c_pin_two_oe_out = pin_oe_r;

   // ***************************************
   // external interrupt sensing
   // ***************************************
   mcirq_sense_det u_sense_b
   (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .sense_in(misc_control_one_r[MCIRQ_SENSE_B_POS +: 2]), // R2
      .pin_in(ext_int_group_b_in),
      .event_out(ext_int_group_b_event_out)
   );

   mcirq_sense_det u_sense_a
   (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .sense_in(misc_control_one_r[MCIRQ_SENSE_A_POS +: 2]), // R3
      .pin_in(ext_int_group_a_in),
      .event_out(ext_int_group_a_event_out)
   );
endmodule

// ### testbench/mcirq_props_properties.sv
// checker for the miscellaneous register ports
// assumes it is bound to mcirq_misc_reg
`timescale 1ns/10ps
module mcirq_props
   import mcirq_pkg::*;
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic int_mask_in,
   input wire logic [MCIRQ_LINES-1:0] ext_int_group_a_in,
   input wire logic [MCIRQ_LINES-1:0] ext_int_group_b_in,
   input wire logic [MCIRQ_LINES-1:0] ext_int_group_a_event_out,
   input wire logic [MCIRQ_LINES-1:0] ext_int_group_b_event_out,
   input wire logic cpu_clock_out,
   input wire logic gpio_pc2_oe_in,
   input wire logic port_c_pin_two_oe_out
);
   logic [7:0] shadow_r; // expected register
   logic [7:0] shadow_nxt;
   logic commit; // write lands on ack edge
   // shadow copy, sense bits kept while unmasked
   always_comb
   begin
      commit = wb_ack_out & wb_cyc_in & wb_stb_in & wb_we_in & wb_sel_in[0]
         & (wb_adr_in[7:2] == 6'h00);
      shadow_nxt = shadow_r;
      if (commit)
         shadow_nxt = int_mask_in ? wb_dat_in[7:0]
            : (wb_dat_in[7:0] & ~MCIRQ_SENSE_MASK) | (shadow_r & MCIRQ_SENSE_MASK);
   end
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         shadow_r <= MCIRQ_MISC_CONTROL_ONE_RST;
      else
         shadow_r <= shadow_nxt;
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack too long");
   a_ack_latency: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("ack late");
   a_read_value: assert property (
      wb_ack_out && !wb_we_in && wb_adr_in[7:2] == 6'h00 |-> wb_dat_out == {24'h0, shadow_r})
      else $error("read data wrong");
   a_level_event: assert property (
      (shadow_r[4:3] == 2'h0 && ext_int_group_a_in == 8'h00)[*4]
      |-> ext_int_group_a_event_out == 8'hFF) else $error("level event missing");
   a_rise_event: assert property (
      (shadow_r[7:6] == 2'h1 && !ext_int_group_b_in[0]) ##1
      (shadow_r[7:6] == 2'h1 && ext_int_group_b_in[0])[*4] |-> ext_int_group_b_event_out[0])
      else $error("rise event missing");
   a_pin_owner: assert property (
      $past(reset_n_in) && port_c_pin_two_oe_out != $past(gpio_pc2_oe_in)
      |-> port_c_pin_two_oe_out) else $error("pin enable wrong");
   a_normal_half: assert property ((!shadow_r[0])[*3] |->
      cpu_clock_out != $past(cpu_clock_out)) else $error("half rate wrong");
   a_slow_quarter: assert property ((shadow_r[2:0] == 3'h1)[*6] |->
      cpu_clock_out != $past(cpu_clock_out, 2)) else $error("quarter rate wrong");
endmodule
bind mcirq_misc_reg mcirq_props mcirq_props_inst (.*);

// ### testbench/mcirq_misc_reg_test.sv
// bench for the miscellaneous register
// assumes the checker file is compiled alongside
`timescale 1ns/10ps
module mcirq_misc_reg_test
   import mcirq_pkg::*;
;
   logic clock_in = 0, reset_n_in = 0, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0;
   logic int_mask_in = 0, gpio_pc2_out_in = 0, gpio_pc2_oe_in = 0, wb_ack_out, cpu_clock_out;
   logic port_c_pin_two_out, port_c_pin_two_oe_out;
   logic [7:0] wb_adr_in = 8'h00;
   logic [3:0] wb_sel_in = 4'h1;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
   logic [7:0] ext_int_group_a_in = 8'hFF, ext_int_group_b_in = 8'hFF;
   logic [7:0] ext_int_group_a_event_out, ext_int_group_b_event_out;
   int n_errors = 0, num_checks = 0, ticks = 0, p;
   int evx[4] = '{6, 1, 1, 2};
   int divx[4] = '{4, 16, 8, 32};
   always #50 clock_in = ~clock_in;
   mcirq_misc_reg mcirq_misc_reg_inst (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one classic bus cycle, read data left in q
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_dat_in <= {24'h0, d};
      do @(posedge clock_in); while (wb_ack_out !== 1'b1);
      q = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask
   // pulse all lines low, count event cycles of line 0; groups get different codes
   task automatic ev(input logic [1:0] c, input int expa, input int expb);
      int na = 0;
      int nb = 0;
      wb(1'b1, 8'h00, {c, 1'b0, ~c, 3'h0});
      for (int k = 0; k < 16; k++)
      begin
         @(posedge clock_in);
         na += (ext_int_group_a_event_out[0] === 1'b1);
         nb += (ext_int_group_b_event_out[0] === 1'b1);
         ext_int_group_a_in <= (k < 6) ? 8'h00 : 8'hFF;
         ext_int_group_b_in <= (k < 6) ? 8'h00 : 8'hFF;
      end
      chk(na, expa);
      chk(nb, expb);
   endtask
   // cpu clock period in oscillator cycles
   task automatic per(output int n);
      realtime t;
      repeat (40) @(posedge clock_in);
      @(posedge cpu_clock_out);
      t = $realtime;
      @(posedge cpu_clock_out);
      n = int'(($realtime - t) / 100.0);
   endtask
   task automatic conclude;
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clock_in)
   begin
      ticks++;
      if (ticks == 30000)
      begin
         n_errors++;
         conclude();
      end
   end
   initial
   begin
      repeat (8) @(posedge clock_in);
      reset_n_in <= 1'b1;
      wb(1'b0, 8'h00, 8'h00);
      chk(q, 32'h0);
      int_mask_in <= 1'b1;
      wb(1'b1, 8'h00, 8'hFF);
      wb(1'b0, 8'h00, 8'h00);
      chk(q, 32'hFF);
      int_mask_in <= 1'b0;
      wb(1'b1, 8'h00, 8'h00);
      wb(1'b0, 8'h00, 8'h00);
      chk(q, 32'hD8);
      wb(1'b1, 8'h00, 8'h27);
      wb(1'b0, 8'h00, 8'h00);
      chk(q, 32'hFF);
      wb(1'b1, 8'h04, 8'h00);
      wb(1'b0, 8'h04, 8'h00);
      chk(q, 32'h0);
      wb(1'b0, 8'h00, 8'h00);
      chk(q, 32'hFF);
      wb_sel_in <= 4'h0;
      wb(1'b1, 8'h00, 8'h00);
      wb_sel_in <= 4'h1;
      wb(1'b0, 8'h00, 8'h00);
      chk(q, 32'hFF);
      int_mask_in <= 1'b1;
      for (int c = 0; c < 4; c++)
         ev(2'(c), evx[3 - c], evx[c]);
      wb(1'b1, 8'h00, 8'h20);
      per(p);
      chk(p, 2);
      chk({31'h0, port_c_pin_two_oe_out}, 32'h1);
      for (int c = 0; c < 4; c++)
      begin
         wb(1'b1, 8'h00, 8'h21 | 8'(c << 1));
         per(p);
         chk(p, divx[c]);
      end
      gpio_pc2_oe_in <= 1'b1;
      gpio_pc2_out_in <= 1'b1;
      wb(1'b1, 8'h00, 8'h00);
      repeat (3) @(posedge clock_in);
      chk({30'h0, port_c_pin_two_oe_out, port_c_pin_two_out}, 32'h3);
      conclude();
   end
endmodule
